// file: hdl/aept_pkg.sv
// constants, states and decode helpers of the analog event trigger
package aept_pkg;
   localparam int NCH_DEF = 254;
   localparam int CH_W = 8;
   localparam int DW = 16;
   localparam int PDO_SH = 2;
   localparam int PW = CH_W - PDO_SH;
   localparam int NPDO = 2 ** PW;
   localparam int FIFO_DEPTH = 16;
   // object dictionary indices
   localparam logic [15:0] IDX_AOUT = 16'h6411;
   localparam logic [15:0] IDX_GEN = 16'h6423;
   localparam logic [15:0] IDX_UP = 16'h6424;
   localparam logic [15:0] IDX_LO = 16'h6425;
   localparam logic [15:0] IDX_DL = 16'h6426;
   localparam logic [7:0] SUB_CNT = 8'h00;
   localparam logic [7:0] SUB_FIRST = 8'h01;
   localparam logic [15:0] VAL_RST = 16'h0000;
   localparam logic GEN_RST = 1'b0;
   localparam logic [1:0] CP_LAST = 2'h3;
   // memory slots
   localparam int NMEM = 6;
   localparam logic [2:0] M_OUT = 3'h0;
   localparam logic [2:0] M_UP = 3'h1;
   localparam logic [2:0] M_LO = 3'h2;
   localparam logic [2:0] M_DL = 3'h3;
   localparam logic [2:0] M_LAST = 3'h4;
   localparam logic [2:0] M_CUR = 3'h5;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_CMP = 3'h1,
      S_ODR = 3'h2,
      S_CPR = 3'h4,
      S_CPW = 3'h5
   } aept_st_t;

   // index to array slot, top bit marks a channel array
   function automatic logic [3:0] aept_sel(input logic [15:0] idx);
      unique case (idx)
         IDX_AOUT: aept_sel = {1'b1, M_OUT};
         IDX_UP: aept_sel = {1'b1, M_UP};
         IDX_LO: aept_sel = {1'b1, M_LO};
         IDX_DL: aept_sel = {1'b1, M_DL};
         default: aept_sel = 4'h0;
      endcase
   endfunction

   // lowest set bit of a pdo vector
   function automatic logic [PW-1:0] aept_first(input logic [NPDO-1:0] v);
      aept_first = '0;
      for (int i = NPDO - 1; i >= 0; i--) begin
         if (v[i]) begin
            aept_first = PW'(i);
         end
      end
   endfunction
endpackage

// file: hdl/aept_mem_if.sv
// carrier between the trigger engine and one channel memory
interface aept_mem_if #(parameter int AW = 8, parameter int DW = 16);
   logic [AW-1:0] addr;
   logic we;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctl(output addr, output we, output wdata, input rdata);
   modport mem(input addr, input we, input wdata, output rdata);
endinterface

// file: hdl/aept_mem.sv
// per-channel word memory with registered read and cleared contents
module aept_mem import aept_pkg::*; #(
   parameter int AW = 8,
   parameter logic [DW-1:0] RST = VAL_RST
) (
   input wire logic clk,
   input wire logic nrst,
   aept_mem_if.mem bus
);
   logic [DW-1:0] ram [2**AW];
   logic [2**AW-1:0] vld_r;

   // storage, no reset on the array itself
   always_ff @(posedge clk) begin
      if (bus.we) begin
         ram[bus.addr] <= bus.wdata;
      end
   end

   // written marks, so unwritten entries read as reset value
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         vld_r <= '0;
      end else if (bus.we) begin
         vld_r[bus.addr] <= 1'b1;
      end
   end

   // read before write on the same address
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus.rdata <= RST;
      end else begin
         bus.rdata <= vld_r[bus.addr] ? ram[bus.addr] : RST;
      end
   end
endmodule

// file: hdl/aept_fifo.sv
// sample fifo with valid/ready on both sides
module aept_fifo #(
   parameter int W = 24,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] buf_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic push;
   logic pop;

   // full when pointers differ only in the wrap bit
   assign in_ready = !((wp_r[AW] != rp_r[AW]) &&
                       (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_valid = (wp_r != rp_r);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = buf_r[rp_r[AW-1:0]];

   // data store
   always_ff @(posedge clk) begin
      if (push) begin
         buf_r[wp_r[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule

// file: hdl/aept_trigger.sv
// analog event trigger: thresholds, output values, tpdo requests
// Function
// - Up to 254 analog output words, read/write, reset 0, with a count.
// - Channel words are left aligned 16-bit values, used as is.
// - No analog event request is made while the global enable is 0.
// - A nonzero upper limit requests the pdo when input exceeds it.
// - A nonzero lower limit requests the pdo when input drops below.
// - A nonzero delta requests the pdo when input moved beyond it.
// - Limits compare unsigned like inputs, delta is a magnitude.
// - Limit and delta arrays hold one word per channel, reset 0 = off.
// - Without monitoring, any unmasked byte change requests the pdo.
// - The byte event mask is ignored once monitoring is active.
module aept_trigger import aept_pkg::*; #(
   parameter int NCH = NCH_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic od_valid,
   output logic od_ready,
   input wire logic od_wr,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_sub,
   input wire logic [DW-1:0] od_wdata,
   output logic od_rsp_valid,
   output logic [DW-1:0] od_rdata,
   output logic od_abort,
   input wire logic ain_valid,
   output logic ain_ready,
   input wire logic [CH_W-1:0] ain_ch,
   input wire logic [DW-1:0] ain_data,
   input wire logic [NPDO*8-1:0] pdo_byte_event_mask,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [PW-1:0] tx_pdo,
   input wire logic tx_sent,
   input wire logic [PW-1:0] tx_sent_pdo,
   output logic aout_wr,
   output logic [CH_W-1:0] aout_ch,
   output logic [DW-1:0] aout_data,
   output logic event_enable
);
   aept_st_t state_r, state_nxt;
   logic [CH_W-1:0] mem_addr;
   logic [DW-1:0] mem_wdata;
   logic [NMEM-1:0] mem_we;
   logic [DW-1:0] rd [NMEM];
   logic f_valid, f_ready;
   logic [CH_W+DW-1:0] f_data;
   logic [3:0] od_sel;
   logic od_take, od_arr_ok, od_cnt;
   logic [2:0] od_slot_r;
   logic gen_en_r;
   logic [NPDO-1:0] pend_r, pend_set, cp_pend_r;
   logic tx_pdo_v_r;
   logic [PW-1:0] cp_pdo_r;
   logic [1:0] cp_k_r;
   logic [CH_W-1:0] smp_ch_r;
   logic [DW-1:0] smp_val_r;
   logic [PW-1:0] smp_pdo;
   logic [7:0] msk;
   logic [3:0] bpos;
   logic [DW-1:0] diff;
   logic mon, up_hit, lo_hit, dl_hit, chg_hit, trig;

   aept_mem_if #(.AW(CH_W), .DW(DW)) m_if [NMEM] ();

   // one memory per channel array, shared address and data
   for (genvar g = 0; g < NMEM; g++) begin : g_mem
      assign m_if[g].addr = mem_addr;
      assign m_if[g].wdata = mem_wdata;
      assign m_if[g].we = mem_we[g];
      assign rd[g] = m_if[g].rdata;
      aept_mem #(.AW(CH_W)) u_mem (
         .clk(clk),
         .nrst(nrst),
         .bus(m_if[g].mem)
      );
   end

   // incoming samples buffered ahead of the compare engine
   aept_fifo #(.W(CH_W + DW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(ain_valid),
      .in_ready(ain_ready),
      .in_data({ain_ch, ain_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // dictionary decode
   assign od_sel = aept_sel(od_index);
   assign od_arr_ok = od_sel[3] && (od_sub >= SUB_FIRST) &&
                      (od_sub <= 8'(NCH));
   assign od_cnt = od_sel[3] && (od_sub == SUB_CNT);
   assign od_take = od_valid && od_ready;
   assign event_enable = gen_en_r;
   assign tx_valid = tx_pdo_v_r;

   // sequencer: copy has priority, then dictionary, then samples
   always_comb begin
      state_nxt = state_r;
      mem_addr = '0;
      mem_wdata = od_wdata;
      mem_we = '0;
      od_ready = 1'b0;
      f_ready = 1'b0;
      unique case (state_r)
         S_IDLE: begin
            if (|cp_pend_r) begin
               state_nxt = S_CPR;
            end else if (od_valid) begin
               od_ready = 1'b1;
               mem_addr = od_sub - SUB_FIRST;
               if (od_arr_ok && od_wr) begin
                  mem_we[od_sel[2:0]] = 1'b1;
               end
               if (od_arr_ok && !od_wr) begin
                  state_nxt = S_ODR;
               end
            end else if (f_valid) begin
               f_ready = 1'b1;
               mem_addr = f_data[CH_W+DW-1:DW];
               mem_wdata = f_data[DW-1:0];
               mem_we[M_CUR] = 1'b1;
               state_nxt = S_CMP;
            end
         end
         S_CMP: state_nxt = S_IDLE;
         S_ODR: state_nxt = S_IDLE;
         S_CPR: begin
            mem_addr = {cp_pdo_r, cp_k_r};
            state_nxt = S_CPW;
         end
         S_CPW: begin
            mem_addr = {cp_pdo_r, cp_k_r};
            mem_wdata = rd[M_CUR];
            mem_we[M_LAST] = 1'b1;
            state_nxt = (cp_k_r == CP_LAST) ? S_IDLE : S_CPR;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= S_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // compare of one sample against its channel settings
   always_comb begin
      smp_pdo = smp_ch_r[CH_W-1:PDO_SH];
      msk = pdo_byte_event_mask[{smp_pdo, 3'h0} +: 8];
      bpos = {1'b0, smp_ch_r[PDO_SH-1:0], 1'b0};
      // delta taken as an unsigned magnitude
      diff = (smp_val_r >= rd[M_LAST]) ? smp_val_r - rd[M_LAST] :
             rd[M_LAST] - smp_val_r;
      mon = (rd[M_UP] != VAL_RST) || (rd[M_LO] != VAL_RST) ||
            (rd[M_DL] != VAL_RST);
      up_hit = (rd[M_UP] != VAL_RST) && (smp_val_r > rd[M_UP]);
      lo_hit = (rd[M_LO] != VAL_RST) && (smp_val_r < rd[M_LO]);
      dl_hit = (rd[M_DL] != VAL_RST) && (diff > rd[M_DL]);
      // masked byte change only without monitoring
      chg_hit = !mon &&
         (((smp_val_r[7:0] != rd[M_CUR][7:0]) && msk[bpos[2:0]]) ||
          ((smp_val_r[15:8] != rd[M_CUR][15:8]) &&
           msk[3'(bpos + 4'h1)]));
      trig = (state_r == S_CMP) && gen_en_r &&
             (up_hit || lo_hit || dl_hit || chg_hit);
      pend_set = '0;
      pend_set[smp_pdo] = trig;
   end

   // sample captured as is, left aligned
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         smp_ch_r <= '0;
         smp_val_r <= VAL_RST;
      end else if (f_valid && f_ready) begin
         smp_ch_r <= f_data[CH_W+DW-1:DW];
         smp_val_r <= f_data[DW-1:0];
      end
   end

   // triggers merge into one pending bit per pdo
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend_r <= '0;
         tx_pdo_v_r <= 1'b0;
         tx_pdo <= '0;
      end else begin
         if (tx_pdo_v_r && tx_ready) begin
            tx_pdo_v_r <= 1'b0;
         end else if (!tx_pdo_v_r && |pend_r) begin
            tx_pdo_v_r <= 1'b1;
            tx_pdo <= aept_first(pend_r);
         end
         // set wins over the clear of the loaded pdo
         pend_r <= (pend_r & ~(((!tx_pdo_v_r && |pend_r) ?
                   NPDO'(1) << aept_first(pend_r) : '0))) | pend_set;
      end
   end

   // sent pdos queue a reference copy
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cp_pend_r <= '0;
         cp_pdo_r <= '0;
         cp_k_r <= '0;
      end else begin
         if (state_r == S_IDLE && |cp_pend_r) begin
            cp_pdo_r <= aept_first(cp_pend_r);
            cp_k_r <= '0;
         end else if (state_r == S_CPW) begin
            cp_k_r <= cp_k_r + 2'h1;
         end
         cp_pend_r <= (cp_pend_r & ~((state_r == S_IDLE && |cp_pend_r) ?
                      NPDO'(1) << aept_first(cp_pend_r) : '0)) |
                      (tx_sent ? NPDO'(1) << tx_sent_pdo : '0);
      end
   end

   // dictionary answers and the global enable
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         od_rsp_valid <= 1'b0;
         od_rdata <= VAL_RST;
         od_abort <= 1'b0;
         od_slot_r <= '0;
         gen_en_r <= GEN_RST;
      end else begin
         od_rsp_valid <= 1'b0;
         if (state_r == S_ODR) begin
            od_rsp_valid <= 1'b1;
            od_rdata <= rd[od_slot_r];
            od_abort <= 1'b0;
         end else if (od_take) begin
            od_slot_r <= od_sel[2:0];
            od_rsp_valid <= !(od_arr_ok && !od_wr);
            od_abort <= 1'b0;
            if (od_cnt) begin
               od_rdata <= DW'(NCH);
               od_abort <= od_wr;
            end else if (od_index == IDX_GEN && od_sub == SUB_CNT) begin
               od_rdata <= DW'(gen_en_r);
               if (od_wr) begin
                  gen_en_r <= od_wdata[0];
               end
            end else if (!od_arr_ok) begin
               od_abort <= 1'b1;
            end
         end
      end
   end

   // output channel update toward the converters
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aout_wr <= 1'b0;
         aout_ch <= '0;
         aout_data <= VAL_RST;
      end else begin
         aout_wr <= od_take && od_wr && od_arr_ok &&
                    od_sel[2:0] == M_OUT;
         if (od_take && od_wr && od_arr_ok && od_sel[2:0] == M_OUT) begin
            aout_ch <= od_sub - SUB_FIRST;
            aout_data <= od_wdata;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_GEN_GATE: assert property (
      (pend_set != '0) |-> gen_en_r && state_r == S_CMP)
      else $error("event request while global enable is off");
   AST_UPPER: assert property (
      state_r == S_CMP && gen_en_r && rd[M_UP] != VAL_RST &&
      smp_val_r > rd[M_UP] |=> pend_r[$past(smp_pdo)])
      else $error("upper limit crossing not requested");
   AST_LOWER: assert property (
      state_r == S_CMP && gen_en_r && rd[M_LO] != VAL_RST &&
      smp_val_r < rd[M_LO] |=> pend_r[$past(smp_pdo)])
      else $error("lower limit crossing not requested");
   AST_DELTA: assert property (
      state_r == S_CMP && gen_en_r && rd[M_DL] != VAL_RST &&
      diff > rd[M_DL] |=> pend_r[$past(smp_pdo)])
      else $error("delta step not requested");
   AST_OFF_QUIET: assert property (
      state_r == S_CMP && !mon && smp_val_r == rd[M_CUR]
      |-> pend_set == '0)
      else $error("request with monitoring off and no change");
   AST_MASK_IGN: assert property (
      state_r == S_CMP && gen_en_r && (up_hit || lo_hit || dl_hit) &&
      msk == 8'h00
      |=> pend_r[$past(smp_pdo)])
      else $error("mask blocked a limit event");
   AST_CHANGE: assert property (
      state_r == S_CMP && gen_en_r && !mon && msk[bpos[2:0]] &&
      smp_val_r[7:0] != rd[M_CUR][7:0] |=> pend_r[$past(smp_pdo)])
      else $error("unmasked change not requested");
   AST_REF_COPY: assert property (
      state_r == S_CPR && cp_k_r == 2'h0 |->
      ##7 (state_r == S_CPW && cp_k_r == CP_LAST))
      else $error("reference copy did not cover four channels");
   AST_ONE_REQ: assert property (
      tx_valid && tx_ready && !(|pend_r) |=> !tx_pdo_v_r)
      else $error("request repeated after handshake");
   AST_CNT_RO: assert property (
      od_take && od_wr && od_cnt |=> od_rsp_valid && od_abort)
      else $error("write to channel count not refused");

   COV_UPPER: cover property (trig && up_hit);
   COV_DELTA: cover property (trig && dl_hit);
   COV_COPY: cover property (state_r == S_CPW && cp_k_r == CP_LAST);
   COV_OD_RD: cover property (state_r == S_ODR ##1 od_rsp_valid);
endmodule

// file: hdl/aept_note_fix.sv
// spare slot of the trigger, holds no logic

// file: verif/aept_tx_partner.sv
// transmit scheduler model facing the trigger request port
module aept_tx_partner import aept_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic stall,
   input wire logic tx_valid,
   input wire logic [PW-1:0] tx_pdo,
   output logic tx_ready,
   output logic tx_sent,
   output logic [PW-1:0] tx_sent_pdo
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [PW-1:0] held;
   logic take_r;
   logic [2:0] cnt;

   // note what was accepted at the sampling edge
   always @(posedge clk) begin
      take_r <= nrst & tx_valid & tx_ready;
      if (tx_valid && tx_ready) begin
         held <= tx_pdo;
      end
   end

   // paced acceptance
   // one request at a time, sent four cycles after acceptance
   always @(negedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_ready <= 1'b0;
         tx_sent <= 1'b0;
         tx_sent_pdo <= '0;
         cnt <= 3'h0;
      end else begin
         tx_sent <= 1'b0;
         tx_sent_pdo <= ~held; // inverse of the held pdo outside the pulse
         if (take_r) begin
            tx_ready <= 1'b0;
            cnt <= 3'h3;
         end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
               tx_sent <= 1'b1;
               tx_sent_pdo <= held;
            end
         end else begin
            tx_ready <= ~stall;
         end
      end
   end
endmodule

// file: verif/testbench.sv
// self-checking bench of the analog event trigger
module testbench;
   import aept_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int NCH_T = 16;
   localparam logic [17:0] WR_OK = 18'h00000;
   localparam logic [17:0] ABORT = 18'h10000;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic od_valid = 1'b0;
   logic od_wr = 1'b0;
   logic [15:0] od_index = 16'h0000;
   logic [7:0] od_sub = 8'h00;
   logic [DW-1:0] od_wdata = 16'h0000;
   logic ain_valid = 1'b0;
   logic [CH_W-1:0] ain_ch = 8'h00;
   logic [DW-1:0] ain_data = 16'h0000;
   logic [NPDO*8-1:0] mask = '1;
   logic stall = 1'b0;
   logic od_ready, od_rsp_valid, od_abort, ain_ready, tx_valid, tx_ready;
   logic tx_sent, aout_wr, event_enable;
   logic [DW-1:0] od_rdata, aout_data;
   logic [PW-1:0] tx_pdo, tx_sent_pdo;
   logic [CH_W-1:0] aout_ch;
   logic [17:0] rsp_q[$];
   logic [PW-1:0] tx_q[$];
   logic [23:0] aout_q[$];
   logic [17:0] ex;
   logic [15:0] idxs [4] = '{IDX_AOUT, IDX_UP, IDX_LO, IDX_DL};
   logic [7:0] ch;
   logic [15:0] d;

   aept_trigger #(.NCH(NCH_T)) u_aept_trigger (.clk(clk), .nrst(nrst),
      .od_valid(od_valid), .od_ready(od_ready), .od_wr(od_wr),
      .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata),
      .od_rsp_valid(od_rsp_valid), .od_rdata(od_rdata),
      .od_abort(od_abort), .ain_valid(ain_valid), .ain_ready(ain_ready),
      .ain_ch(ain_ch), .ain_data(ain_data), .pdo_byte_event_mask(mask),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pdo(tx_pdo),
      .tx_sent(tx_sent), .tx_sent_pdo(tx_sent_pdo), .aout_wr(aout_wr),
      .aout_ch(aout_ch), .aout_data(aout_data),
      .event_enable(event_enable));

   aept_tx_partner u_aept_tx_partner (.clk(clk), .nrst(nrst),
      .stall(stall), .tx_valid(tx_valid), .tx_pdo(tx_pdo),
      .tx_ready(tx_ready), .tx_sent(tx_sent), .tx_sent_pdo(tx_sent_pdo));

   // 25 MHz clock
   always #20 clk = ~clk;

   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   function automatic logic [17:0] rd(input logic [15:0] v);
      rd = {2'b10, v};
   endfunction

   // one dictionary request, held until taken, then wait for its answer
   task automatic od_req(input logic wr, input logic [15:0] idx,
         input logic [7:0] sub, input logic [15:0] wd, input logic [17:0] e);
      int n;
      logic got;
      rsp_q.push_back(e);
      @(negedge clk);
      od_valid = 1'b1;
      od_wr = wr;
      od_index = idx;
      od_sub = sub;
      od_wdata = wd;
      n = 0;
      do begin
         #1;
         got = od_ready;
         @(posedge clk);
         n++;
      end while (!got && n < 100);
      if (!got) check("od_ready", 32'h0, 32'h1);
      @(negedge clk);
      od_valid = 1'b0;
      n = 0;
      while (rsp_q.size() != 0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (rsp_q.size() != 0) check("od_rsp", 32'h0, 32'h1);
   endtask

   task automatic wr_ch(input logic [15:0] idx, input logic [7:0] c,
         input logic [15:0] v);
      if (idx == IDX_AOUT) begin
         aout_q.push_back({c, v});
      end
      od_req(1'b1, idx, c + 8'h01, v, WR_OK);
   endtask

   // one input sample through the valid/ready handshake
   task automatic sample(input logic [7:0] c, input logic [15:0] v);
      int n;
      logic got;
      @(negedge clk);
      ain_valid = 1'b1;
      ain_ch = c;
      ain_data = v;
      n = 0;
      do begin
         #1;
         got = ain_ready;
         @(posedge clk);
         n++;
      end while (!got && n < 100);
      if (!got) check("ain_ready", 32'h0, 32'h1);
      @(negedge clk);
      ain_valid = 1'b0;
   endtask

   task automatic settle();
      repeat (40) @(posedge clk);
      check("tx_left", 32'(tx_q.size()), 32'h0);
   endtask

   // answers, requests and output writes against the oldest notes
   always @(posedge clk) begin
      if (nrst && od_rsp_valid) begin
         ex = (rsp_q.size() == 0) ? 18'h3FFFF : rsp_q.pop_front();
         check("od_abort", 32'(od_abort), 32'(ex[16]));
         if (ex[17]) check("od_rdata", 32'(od_rdata), 32'(ex[15:0]));
      end
      if (nrst && tx_valid && tx_ready) begin
         if (tx_q.size() == 0) check("tx_extra", 32'h1, 32'h0);
         else check("tx_pdo", 32'(tx_pdo), 32'(tx_q.pop_front()));
      end
      if (nrst && aout_wr) begin
         if (aout_q.size() == 0) check("aout_extra", 32'h1, 32'h0);
         else check("aout", {aout_ch, aout_data}, aout_q.pop_front());
      end
   end

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end

   initial begin
      void'($urandom(32'h8831));
      mask[31:24] = 8'h00;
      repeat (6) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      foreach (idxs[i]) begin
         od_req(1'b0, idxs[i], SUB_CNT, 16'h0000, rd(16'(NCH_T)));
         od_req(1'b0, idxs[i], SUB_FIRST, 16'h0000, rd(VAL_RST));
      end
      od_req(1'b0, IDX_GEN, SUB_CNT, 16'h0000, rd(16'h0000));
      check("event_enable", 32'(event_enable), 32'h0);
      $display("test reset done");
      foreach (idxs[i]) begin
         ch = 8'($urandom % NCH_T);
         d = 16'($urandom);
         wr_ch(idxs[i], ch, d);
         od_req(1'b0, idxs[i], ch + 8'h01, 16'h0000, rd(d));
         wr_ch(idxs[i], ch, VAL_RST);
      end
      $display("test read write done");
      od_req(1'b1, IDX_UP, SUB_CNT, 16'h1111, ABORT);
      od_req(1'b0, IDX_LO, 8'hFF, 16'h0000, ABORT);
      od_req(1'b1, 16'h6427, SUB_FIRST, 16'h1111, ABORT);
      $display("test refusal done");
      // random stall and mask must not matter while disabled
      repeat (24) begin
         @(negedge clk);
         stall = 1'($urandom);
         mask[63:0] = {$urandom, $urandom};
         sample(8'($urandom % NCH_T), 16'($urandom));
      end
      @(negedge clk);
      stall = 1'b0;
      mask = '1;
      mask[31:24] = 8'h00;
      settle();
      $display("test disabled burst done");
      wr_ch(IDX_UP, 8'h01, 16'h8000);
      wr_ch(IDX_LO, 8'h05, 16'h1000);
      wr_ch(IDX_DL, 8'h09, 16'h0100);
      od_req(1'b1, IDX_GEN, SUB_CNT, 16'h0001, WR_OK);
      @(negedge clk);
      check("event_enable", 32'(event_enable), 32'h1);
      tx_q.push_back(6'h00);
      sample(8'h01, 16'h9000);
      settle();
      tx_q.push_back(6'h01);
      sample(8'h05, 16'h0800);
      settle();
      tx_q.push_back(6'h02);
      sample(8'h09, 16'h0200);
      settle();
      tx_q.push_back(6'h02);
      sample(8'h09, 16'h0050);
      settle();
      $display("test limits and delta done");
      sample(8'h0C, 16'h1234);
      settle();
      @(negedge clk);
      mask[31:24] = 8'h03;
      tx_q.push_back(6'h03);
      sample(8'h0C, 16'h5678);
      settle();
      @(negedge clk);
      mask[15:8] = 8'h00;
      tx_q.push_back(6'h01);
      sample(8'h05, 16'h0400);
      settle();
      $display("test byte mask done");
      @(negedge clk);
      stall = 1'b1;
      // first request held, two later triggers merge into one more
      tx_q.push_back(6'h00);
      tx_q.push_back(6'h00);
      sample(8'h01, 16'h9100);
      sample(8'h01, 16'h9200);
      sample(8'h01, 16'h9300);
      repeat (10) @(posedge clk);
      @(negedge clk);
      stall = 1'b0;
      settle();
      $display("test merged request done");
      od_req(1'b1, IDX_GEN, SUB_CNT, 16'h0000, WR_OK);
      sample(8'h01, 16'hA000);
      settle();
      check("aout_left", 32'(aout_q.size()), 32'h0);
      $display("test disable done");
      complete_run();
   end
endmodule
